// ### hw/qpc_pkg.sv
package qpc_pkg;

    // Register map, byte addresses on the software port.
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] LOAD_ADDR = 8'h04;
    localparam logic [7:0] COUNT_ADDR = 8'h08;
    localparam logic [7:0] FREQ_ADDR = 8'h0C;
    localparam logic [7:0] STATUS_ADDR = 8'h10;

    // Control register field positions.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_BAND_BIT = 2;
    localparam int CTRL_FREEZE_BIT = 3;
    localparam int CTRL_IDX_EN_BIT = 4;
    localparam int CTRL_ES_EN_BIT = 5;
    localparam int CTRL_LOAD_BIT = 6;
    localparam int CTRL_WIDTH = 7;

    // Status register field positions.
    localparam int STAT_A_BIT = 0;
    localparam int STAT_B_BIT = 1;
    localparam int STAT_IDX_BIT = 2;
    localparam int STAT_ES_BIT = 3;

    localparam int COUNT_W = 32;
    localparam int FREQ_W = 16;
    localparam int WIN_W = 28;

    typedef enum logic [1:0] {
        QPC_STEP_DIR,
        QPC_DUAL_PULSE,
        QPC_QUAD
    } qpc_mode_t;

    typedef enum logic {
        QPC_BAND_LOW,
        QPC_BAND_HIGH
    } qpc_band_t;

    // Reset values.
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 7'h00;
    localparam logic [COUNT_W-1:0] LOAD_RESET = 32'h00000000;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h00000000;
    localparam logic [FREQ_W-1:0] FREQ_RESET = 16'h0000;

    // Measurement windows and the clock rate they are counted in.
    localparam longint CLK_HZ = 200000000;
    localparam longint WIN_LOW_MS = 1000;
    localparam longint WIN_HIGH_MS = 200;
    localparam int WIN_LOW_CYCLES = int'(WIN_LOW_MS * CLK_HZ / 1000);
    localparam int WIN_HIGH_CYCLES = int'(WIN_HIGH_MS * CLK_HZ / 1000);

endpackage

// ### hw/qpc_top.sv
// Function
// - Each of the four field inputs is mirrored to its own status bit.
// - Step/direction mode counts first-input pulses, direction from second input.
// - Dual-pulse mode counts up on first input, down on second input.
// - Quadrature mode counts up when first leads, down when second leads.
// - Step/direction is the mode after reset.
// - A band select chooses low rates (to 30 kHz) or high rates (from 30 kHz).
// - Frequency window is 1 s in the low band, 200 ms in the high band.
// - The pulse total of each window is reported as a 16-bit signed value.
// - The count is always presented as a 32-bit signed value.
// - Freeze stops counting but not presets; release resumes from the held value.
// - Any active preset source loads the count with the load value.
// - With index load enabled, the index rising edge loads the count.
// - With end-stop load enabled, the end-stop rising edge loads the count.
// - Both load enables reset disabled; then those inputs never touch the count.
// - While load request is one, the count is held at the load value.
// - Counting proceeds whether or not the status bits are read.
module qpc_top #(
    parameter int WIN_LOW_CYCLES = qpc_pkg::WIN_LOW_CYCLES,
    parameter int WIN_HIGH_CYCLES = qpc_pkg::WIN_HIGH_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic PULSE_A,
    input wire logic PULSE_B,
    input wire logic INDEX_IN,
    input wire logic END_STOP_IN,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic [31:0] COUNT_VALUE,
    output logic [15:0] FREQ_VALUE,
    output logic [3:0] INPUT_LEVEL
);

    localparam logic [qpc_pkg::WIN_W-1:0] WIN_LOW_LAST = qpc_pkg::WIN_W'(WIN_LOW_CYCLES - 1);
    localparam logic [qpc_pkg::WIN_W-1:0] WIN_HIGH_LAST = qpc_pkg::WIN_W'(WIN_HIGH_CYCLES - 1);

    logic [qpc_pkg::CTRL_WIDTH-1:0] ctrl_q;
    logic [qpc_pkg::CTRL_WIDTH-1:0] ctrl_d;
    logic [31:0] load_q;
    logic [31:0] load_d;
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic [15:0] freq_q;
    logic [15:0] freq_d;
    logic [15:0] acc_q;
    logic [15:0] acc_d;
    logic [qpc_pkg::WIN_W-1:0] win_q;
    logic [qpc_pkg::WIN_W-1:0] win_d;
    logic [3:0] in_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Control fields.
    wire qpc_pkg::qpc_mode_t mode = qpc_pkg::qpc_mode_t'(ctrl_q[qpc_pkg::CTRL_MODE_LSB +: 2]);
    wire qpc_pkg::qpc_band_t band = qpc_pkg::qpc_band_t'(ctrl_q[qpc_pkg::CTRL_BAND_BIT]);
    wire freeze = ctrl_q[qpc_pkg::CTRL_FREEZE_BIT];
    wire idx_load_en = ctrl_q[qpc_pkg::CTRL_IDX_EN_BIT];
    wire es_load_en = ctrl_q[qpc_pkg::CTRL_ES_EN_BIT];
    wire load_request = ctrl_q[qpc_pkg::CTRL_LOAD_BIT];

    // Previous sampled levels of the field inputs.
    wire a_old = in_q[qpc_pkg::STAT_A_BIT];
    wire b_old = in_q[qpc_pkg::STAT_B_BIT];
    wire idx_old = in_q[qpc_pkg::STAT_IDX_BIT];
    wire es_old = in_q[qpc_pkg::STAT_ES_BIT];

    wire a_rise = PULSE_A & ~a_old;
    wire b_rise = PULSE_B & ~b_old;
    wire a_edge = PULSE_A ^ a_old;
    wire b_edge = PULSE_B ^ b_old;

    // Register port decode.
    wire wr_ctrl = WR & (ADDR == qpc_pkg::CTRL_ADDR);
    wire wr_load = WR & (ADDR == qpc_pkg::LOAD_ADDR);
    wire rd_ctrl = ADDR == qpc_pkg::CTRL_ADDR;
    wire rd_load = ADDR == qpc_pkg::LOAD_ADDR;
    wire rd_count = ADDR == qpc_pkg::COUNT_ADDR;
    wire rd_freq = ADDR == qpc_pkg::FREQ_ADDR;
    wire rd_stat = ADDR == qpc_pkg::STATUS_ADDR;

    // Step/direction: one count per rising edge of the pulse input.
    wire sd_step = a_rise;
    wire sd_up = PULSE_B;

    // Dual pulse: simultaneous up and down pulses cancel.
    wire dp_up = a_rise & ~b_rise;
    wire dp_dn = b_rise & ~a_rise;

    // Quadrature, counting every edge of both inputs. A change of both inputs
    // in one sample is a lost phase and is ignored rather than guessed.
    wire q_valid = a_edge ^ b_edge;
    wire q_up_a = a_edge & (PULSE_A ^ b_old);
    wire q_up_b = b_edge & ~(PULSE_B ^ a_old);
    wire q_up = q_valid & (q_up_a | q_up_b);
    wire q_dn = q_valid & ~(q_up_a | q_up_b);

    logic step_up;
    logic step_dn;

    always_comb begin
        unique case (mode)
            qpc_pkg::QPC_DUAL_PULSE: begin
                step_up = dp_up;
                step_dn = dp_dn;
            end
            qpc_pkg::QPC_QUAD: begin
                step_up = q_up;
                step_dn = q_dn;
            end
            // The unused code counts as step/direction.
            default: begin
                step_up = sd_step & sd_up;
                step_dn = sd_step & ~sd_up;
            end
        endcase
    end

    // Preset sources. With the enables clear, the index and end-stop inputs
    // only reach the status bits.
    wire idx_load = idx_load_en & INDEX_IN & ~idx_old;
    wire es_load = es_load_en & END_STOP_IN & ~es_old;
    wire preset = load_request | idx_load | es_load;

    wire counting = ~preset & ~freeze;
    wire count_up = counting & step_up;
    wire count_dn = counting & step_dn;

    always_comb begin
        count_d = count_q;
        if (preset) begin
            count_d = load_q;
        end else if (count_up) begin
            count_d = count_q + 32'h00000001;
        end else if (count_dn) begin
            count_d = count_q - 32'h00000001;
        end
    end

    // Frequency window. A band change takes effect at once: a window already
    // past the new length ends on the next cycle.
    wire [qpc_pkg::WIN_W-1:0] win_last = (band == qpc_pkg::QPC_BAND_HIGH) ? WIN_HIGH_LAST : WIN_LOW_LAST;
    wire win_end = win_q >= win_last;

    // Net pulses accepted into the count this window.
    logic [15:0] acc_step;

    always_comb begin
        acc_step = acc_q;
        if (count_up) begin
            acc_step = acc_q + 16'h0001;
        end else if (count_dn) begin
            acc_step = acc_q - 16'h0001;
        end
    end

    always_comb begin
        win_d = win_q + qpc_pkg::WIN_W'(1);
        acc_d = acc_step;
        freq_d = freq_q;
        if (win_end) begin
            win_d = '0;
            acc_d = 16'h0000;
            freq_d = acc_step;
        end
    end

    // Software writes. Load request is a level held by software.
    always_comb begin
        ctrl_d = ctrl_q;
        load_d = load_q;
        if (wr_ctrl) begin
            ctrl_d = WDATA[qpc_pkg::CTRL_WIDTH-1:0];
        end
        if (wr_load) begin
            load_d = WDATA;
        end
    end

    // Read data stand for exactly one cycle after the strobe.
    always_comb begin
        rdata_d = 32'h00000000;
        if (RD) begin
            if (rd_ctrl) begin
                rdata_d = {25'h0000000, ctrl_q};
            end else if (rd_load) begin
                rdata_d = load_q;
            end else if (rd_count) begin
                rdata_d = count_q;
            end else if (rd_freq) begin
                rdata_d = {{16{freq_q[15]}}, freq_q};
            end else if (rd_stat) begin
                rdata_d = {28'h0000000, in_q};
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_q <= qpc_pkg::CTRL_RESET;
            load_q <= qpc_pkg::LOAD_RESET;
        end else if (CE) begin
            ctrl_q <= ctrl_d;
            load_q <= load_d;
        end
    end

    // The count runs regardless of status reads.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            count_q <= qpc_pkg::COUNT_RESET;
        end else if (CE) begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            win_q <= '0;
            acc_q <= qpc_pkg::FREQ_RESET;
            freq_q <= qpc_pkg::FREQ_RESET;
        end else if (CE) begin
            win_q <= win_d;
            acc_q <= acc_d;
            freq_q <= freq_d;
        end
    end

    // Input levels double as the edge history and the status mirror.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            in_q <= 4'h0;
        end else if (CE) begin
            in_q <= {END_STOP_IN, INDEX_IN, PULSE_B, PULSE_A};
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_q <= 32'h00000000;
        end else if (CE) begin
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;
    assign COUNT_VALUE = count_q;
    assign FREQ_VALUE = freq_q;
    assign INPUT_LEVEL = in_q;

endmodule

// ### dv/qpc_properties.sv
module qpc_props (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PULSE_A,
    input wire logic PULSE_B,
    input wire logic INDEX_IN,
    input wire logic END_STOP_IN,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic [31:0] COUNT_VALUE,
    input wire logic [3:0] INPUT_LEVEL
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] ctrl_q;
    logic [31:0] ld_q;
    // Shadows of the two writable registers, so presets can be predicted from the port alone.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_q <= 7'h00;
            ld_q <= 32'h00000000;
        end else if (WR && ADDR == qpc_pkg::CTRL_ADDR) begin
            ctrl_q <= WDATA[6:0];
        end else if (WR && ADDR == qpc_pkg::LOAD_ADDR) begin
            ld_q <= WDATA;
        end
    end
    wire logic run = ctrl_q[6:3] == 4'h0;
    wire logic [1:0] md = ctrl_q[1:0];
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_a_leads;
        $rose(PULSE_A) && $stable(PULSE_B) && !PULSE_B;
    endsequence
    // The mirror flops sit in reset on the release edge, so that edge is no reference for the inputs.
    property p_mirror;
        !RESET |=> INPUT_LEVEL == $past({END_STOP_IN, INDEX_IN, PULSE_B, PULSE_A});
    endproperty
    a_mirror: assert property (p_mirror) else $error("level mirror wrong");
    property p_load;
        ctrl_q[6] |=> COUNT_VALUE == $past(ld_q);
    endproperty
    a_load: assert property (p_load) else $error("load hold wrong");
    property p_freeze;
        ctrl_q[6:3] == 4'h1 |=> $stable(COUNT_VALUE);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen count moved");
    property p_index;
        ctrl_q[4] && $rose(INDEX_IN) |=> COUNT_VALUE == $past(ld_q);
    endproperty
    a_index: assert property (p_index) else $error("index load wrong");
    property p_stop;
        ctrl_q[5] && $rose(END_STOP_IN) |=> COUNT_VALUE == $past(ld_q);
    endproperty
    a_stop: assert property (p_stop) else $error("end stop load wrong");
    property p_quiet;
        run && md == 2'h0 && !$rose(PULSE_A) |=> $stable(COUNT_VALUE);
    endproperty
    a_quiet: assert property (p_quiet) else $error("count moved idle");
    property p_step;
        run && md == 2'h0 && $rose(PULSE_A) |=>
            COUNT_VALUE == $past(COUNT_VALUE) + ($past(PULSE_B) ? 32'h00000001 : 32'hFFFFFFFF);
    endproperty
    a_step: assert property (p_step) else $error("step count wrong");
    property p_dual;
        run && md == 2'h1 && $rose(PULSE_A) && !$rose(PULSE_B) |=>
            COUNT_VALUE == $past(COUNT_VALUE) + 32'h00000001;
    endproperty
    a_dual: assert property (p_dual) else $error("dual up count wrong");
    property p_quad;
        (run && md == 2'h2) ##0 s_a_leads |=> COUNT_VALUE == $past(COUNT_VALUE) + 32'h00000001;
    endproperty
    a_quad: assert property (p_quad) else $error("quad count wrong");
    property p_read;
        RD && ADDR == qpc_pkg::COUNT_ADDR |=> RDATA == $past(COUNT_VALUE);
    endproperty
    a_read: assert property (p_read) else $error("count read wrong");
endmodule

// ### dv/qpc_encoder.sv
module qpc_encoder (
    input wire logic clk,
    output logic a,
    output logic b
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        a = 1'b0;
        b = 1'b0;
    end
    // Levels last at least two cycles so no edge is ever shorter than the sampler needs.
    task automatic step(input logic [1:0] mode, input logic up);
        logic [1:0] ph;
        @(posedge clk);
        if (mode == 2'h2) begin
            ph = {b, a ^ b} + (up ? 2'h1 : 2'h3);
            a <= ph[1] ^ ph[0];
            b <= ph[1];
            @(posedge clk);
        end else begin
            a <= 1'b0;
            b <= mode == 2'h1 ? 1'b0 : up;
            repeat (2) @(posedge clk);
            a <= mode == 2'h1 ? up : 1'b1;
            b <= mode == 2'h1 ? !up : up;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

// ### dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [6:0] c; logic up; logic [7:0] n; logic [31:0] d;} qpc_row_t;
    logic clk = 1'b0, rst = 1'b1, idx = 1'b0, es = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000, rdata, count, exp_q = 32'h00000000;
    logic [15:0] freq;
    logic [3:0] lvl;
    wire logic pa, pb;
    int mismatches = 0, compares = 0, cycles = 0;
    qpc_row_t rows [9] = '{'{7'h00, 1, 3, 3}, '{7'h00, 0, 2, -2}, '{7'h03, 1, 2, 2}, '{7'h01, 1, 4, 4},
        '{7'h01, 0, 5, -5}, '{7'h02, 1, 6, 6}, '{7'h02, 0, 7, -7}, '{7'h0A, 1, 4, 0}, '{7'h02, 1, 1, 1}};
    qpc_top #(.WIN_LOW_CYCLES(50), .WIN_HIGH_CYCLES(10)) qpc_top_i (.CLK(clk), .RESET(rst), .CE(1'b1),
        .PULSE_A(pa), .PULSE_B(pb), .INDEX_IN(idx), .END_STOP_IN(es), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .COUNT_VALUE(count), .FREQ_VALUE(freq), .INPUT_LEVEL(lvl));
    qpc_encoder qpc_encoder_i (.clk(clk), .a(pa), .b(pb));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] want, input string what);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] want, input string what);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        check(rdata, want, what);
    endtask
    task cnt(input string what);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(count, exp_q, what);
        rd(qpc_pkg::COUNT_ADDR, exp_q, what);
        $display("test %s done", what);
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        cnt("reset");
        check({12'h000, freq, lvl}, 32'h00000000, "reset outputs");
        rd(qpc_pkg::CTRL_ADDR, 32'h00000000, "reset ctrl");
        foreach (rows[i]) begin
            wr(qpc_pkg::CTRL_ADDR, {25'h0, rows[i].c});
            for (int k = 0; k < rows[i].n; k++) qpc_encoder_i.step(rows[i].c[1:0], rows[i].up);
            exp_q = exp_q + rows[i].d;
            cnt("row");
        end
        wr(qpc_pkg::LOAD_ADDR, 32'hFFFFFFF0);
        wr(qpc_pkg::CTRL_ADDR, 32'h0000004A);
        qpc_encoder_i.step(2'h2, 1'b1);
        exp_q = 32'hFFFFFFF0;
        cnt("load held");
        rd(qpc_pkg::LOAD_ADDR, 32'hFFFFFFF0, "load value");
        wr(qpc_pkg::CTRL_ADDR, 32'h00000002);
        qpc_encoder_i.step(2'h2, 1'b1);
        exp_q = 32'hFFFFFFF1;
        cnt("load released");
        wr(qpc_pkg::LOAD_ADDR, 32'h12345678);
        wr(qpc_pkg::CTRL_ADDR, 32'h00000012);
        idx <= 1'b1;
        exp_q = 32'h12345678;
        cnt("index load");
        wr(qpc_pkg::LOAD_ADDR, 32'h80000000);
        wr(qpc_pkg::CTRL_ADDR, 32'h00000028);
        es <= 1'b1;
        exp_q = 32'h80000000;
        cnt("end stop load");
        wr(qpc_pkg::CTRL_ADDR, 32'h00000000);
        {idx, es} <= 2'b00;
        repeat (3) @(posedge clk);
        {idx, es} <= 2'b11;
        wr(qpc_pkg::COUNT_ADDR, 32'h00000000);
        cnt("plain inputs");
        check(lvl, {2'b11, pb, pa}, "level");
        rd(qpc_pkg::STATUS_ADDR, {28'h0, 2'b11, pb, pa}, "status");
        rd(8'h20, 32'h00000000, "unmapped");
        wr(qpc_pkg::CTRL_ADDR, 32'h00000002);
        // Steady steps every two cycles give a known total in any whole window.
        for (int k = 0; k < 100; k++) begin
            qpc_encoder_i.step(2'h2, 1'b1);
            if (k == 90) begin
                @(negedge clk);
                check(freq, 16'h0019, "low band freq");
            end
        end
        wr(qpc_pkg::CTRL_ADDR, 32'h00000006);
        for (int k = 0; k < 30; k++) begin
            qpc_encoder_i.step(2'h2, 1'b0);
            if (k == 25) begin
                @(negedge clk);
                check(freq, 16'hFFFB, "high band freq");
                // The read lands before any window that holds the pause can close.
                rd(qpc_pkg::FREQ_ADDR, 32'hFFFFFFFB, "freq read");
            end
        end
        $display("test freq done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        exp_q = 32'h00000000;
        cnt("second reset");
        tally_and_finish();
    end
endmodule
bind qpc_top qpc_props qpc_props_i (.CLK, .RESET, .PULSE_A, .PULSE_B, .INDEX_IN, .END_STOP_IN, .ADDR,
    .WDATA, .WR, .RD, .RDATA, .COUNT_VALUE, .INPUT_LEVEL);
